// *** logic/range_check_pkg.sv ***
`default_nettype none
package range_check_pkg;
  localparam int          NUM_CHAN = 8;
  localparam int          CODE_W   = 20;
  localparam int          ADDR_W   = 12;
  localparam int          IDX_LSB  = 2;
  localparam int          IDX_W    = 8;
  localparam int          CNT_W    = 17;
  localparam int          ACC_W    = CODE_W + CNT_W;
  // register indices; byte address is four times the index
  localparam logic [7:0]  CH_UPPER_IDX [NUM_CHAN] = '{8'h32, 8'h44, 8'h56, 8'h68, 8'h7a, 8'h8c, 8'h9e, 8'hb0};
  localparam logic [7:0]  CH_LOWER_IDX [NUM_CHAN] = '{8'h35, 8'h47, 8'h59, 8'h6b, 8'h7d, 8'h8f, 8'ha1, 8'hb3};
  localparam logic [7:0]  GROUP_BYTES  = 8'h03;
  localparam logic [7:0]  STATUS_IDX   = 8'hc0;
  localparam logic [7:0]  CLEAR_IDX    = 8'hc1;
  localparam logic [7:0]  ENABLE_IDX   = 8'hc2;
  localparam logic [7:0]  CTRL_IDX     = 8'hc3;
  localparam int          UPPER_LSB    = 0;
  localparam int          LOWER_LSB    = 8;
  localparam int          CTRL_EN_BIT  = 0;
  localparam int          CTRL_RAT_LSB = 4;
  localparam logic [19:0] FS_POS       = 20'h7ffff;
  localparam logic [19:0] FS_NEG       = 20'h80000;
  localparam logic [3:0]  RATIO_RESET  = 4'h0;

  typedef struct packed {
    logic                             valid;
    logic [NUM_CHAN-1:0][CODE_W-1:0]  code;
  } sample_bus_t;

  typedef struct packed {
    logic       hit;
    logic       lower;
    logic [2:0] chan;
    logic [1:0] sel;
  } lim_dec_t;
endpackage : range_check_pkg
`default_nettype wire

// *** logic/limit_compare.sv ***
`timescale 1ns/100ps
`default_nettype none
module limit_compare #(
  parameter int CODE_W = 20
) (
  input  wire logic [CODE_W-1:0] code,   // conversion result
  input  wire logic [CODE_W-1:0] upper,  // signed upper limit
  input  wire logic [CODE_W-1:0] lower,  // signed lower limit
  input  wire logic              check,  // result valid this cycle
  output logic                   over,   // strictly above upper
  output logic                   under   // strictly below lower
);
  assign over  = check && ($signed(code) > $signed(upper));   // RULE_09
  assign under = check && ($signed(code) < $signed(lower));   // RULE_09
endmodule : limit_compare
`default_nettype wire

// *** logic/channel_range_limit_checker.sv ***
// How it works
// RULE_01: every conversion of every channel is compared with that channel's signed 20-bit upper and lower limit.
// RULE_02: an upper violation sets the channel bit in the upper flags, a lower violation the one in the lower flags.
// RULE_03: in averaging mode each single contributing conversion is checked, not only the average.
// RULE_04: after reset upper limits hold bipolar positive full scale and lower limits negative full scale.
// RULE_05: software writes its own signed 20-bit codes into the limit registers to replace the defaults.
// RULE_06: each upper limit is a three-byte group, channel 0 at index 0x32 through channel 7 at 0xb0.
// RULE_07: each lower limit is a three-byte group, channel 0 at index 0x35 through channel 7 at 0xb3.
// RULE_08: with averaging on all channels share one ratio and only the averages are presented.
// RULE_09: strictly greater is over, strictly less is under, and flags stay set until software clears them.
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module channel_range_limit_checker #(
  parameter int NUM_CHAN = range_check_pkg::NUM_CHAN,
  parameter int CODE_W   = range_check_pkg::CODE_W
) (
  input  wire logic                                pclk,     // bus and core clock
  input  wire logic                                presetn,  // async reset, active low
  input  wire logic                                psel,     // apb select
  input  wire logic                                penable,  // apb access phase
  input  wire logic                                pwrite,   // apb direction
  input  wire logic [range_check_pkg::ADDR_W-1:0]  paddr,    // apb byte address
  input  wire logic [31:0]                         pwdata,   // apb write data
  input  wire logic [3:0]                          pstrb,    // apb byte strobes
  output logic      [31:0]                         prdata,   // apb read data
  output logic                                     pready,   // apb ready
  output logic                                     pslverr,  // apb error
  input  wire range_check_pkg::sample_bus_t        samples,  // raw conversions
  output range_check_pkg::sample_bus_t             averaged, // presented results
  output logic                                     irq       // level interrupt
);
  localparam int CNT_W = range_check_pkg::CNT_W;
  localparam int ACC_W = range_check_pkg::ACC_W;

  function automatic range_check_pkg::lim_dec_t decode_limit(input logic [7:0] idx);
    range_check_pkg::lim_dec_t d;
    logic [7:0] ofs;
    d = '0;
    ofs = '0;
    for (int c = 0; c < NUM_CHAN; c++) begin
      ofs = idx - range_check_pkg::CH_UPPER_IDX[c];
      if (ofs < range_check_pkg::GROUP_BYTES) begin
        d = '{hit: 1'b1, lower: 1'b0, chan: 3'(c), sel: ofs[1:0]};  // RULE_06
      end
      ofs = idx - range_check_pkg::CH_LOWER_IDX[c];
      if (ofs < range_check_pkg::GROUP_BYTES) begin
        d = '{hit: 1'b1, lower: 1'b1, chan: 3'(c), sel: ofs[1:0]};  // RULE_07
      end
    end
    return d;
  endfunction : decode_limit

  function automatic logic [7:0] limit_byte(input logic [CODE_W-1:0] lim, input logic [1:0] sel);
    logic [23:0] wide;
    wide = 24'(lim);
    case (sel)
      2'h0:    limit_byte = wide[7:0];
      2'h1:    limit_byte = wide[15:8];
      default: limit_byte = wide[23:16];
    endcase
  endfunction : limit_byte

  // apb decode
  wire logic [7:0]                idx      = paddr[range_check_pkg::IDX_LSB +: range_check_pkg::IDX_W];
  wire logic                      aligned  = (paddr[1:0] == 2'h0) && (paddr[range_check_pkg::ADDR_W-1:10] == '0);
  wire range_check_pkg::lim_dec_t dec      = decode_limit(idx);
  wire logic                      is_stat  = aligned && (idx == range_check_pkg::STATUS_IDX);
  wire logic                      is_clr   = aligned && (idx == range_check_pkg::CLEAR_IDX);
  wire logic                      is_ena   = aligned && (idx == range_check_pkg::ENABLE_IDX);
  wire logic                      is_ctrl  = aligned && (idx == range_check_pkg::CTRL_IDX);
  wire logic                      is_lim   = aligned && dec.hit;
  wire logic                      mapped   = is_stat || is_clr || is_ena || is_ctrl || is_lim;
  wire logic                      setup    = psel && !penable;
  wire logic                      wr_acc   = psel && penable && pwrite && mapped && pstrb[0];
  wire logic                      wr_lim   = wr_acc && is_lim;
  wire logic                      wr_clr   = wr_acc && is_clr;
  wire logic                      wr_ena   = wr_acc && is_ena;
  wire logic                      wr_ctrl  = wr_acc && is_ctrl;

  assign pready = 1'b1;

  // registers
  logic [CODE_W-1:0]   upper_limit [NUM_CHAN];
  logic [CODE_W-1:0]   lower_limit [NUM_CHAN];
  logic [NUM_CHAN-1:0] upper_violation_flags;
  logic [NUM_CHAN-1:0] lower_violation_flags;
  logic [15:0]         irq_enable;
  logic                averaging_enable;
  logic [3:0]          averaging_ratio;
  logic                limits_touched;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int c = 0; c < NUM_CHAN; c++) begin
        upper_limit[c] <= range_check_pkg::FS_POS;  // RULE_04
        lower_limit[c] <= range_check_pkg::FS_NEG;  // RULE_04
      end
    end else if (wr_lim) begin
      // RULE_05
      for (int c = 0; c < NUM_CHAN; c++) begin
        if (dec.chan == 3'(c) && !dec.lower) begin
          case (dec.sel)
            2'h0:    upper_limit[c][7:0]   <= pwdata[7:0];
            2'h1:    upper_limit[c][15:8]  <= pwdata[7:0];
            default: upper_limit[c][19:16] <= pwdata[3:0];
          endcase
        end
        if (dec.chan == 3'(c) && dec.lower) begin
          case (dec.sel)
            2'h0:    lower_limit[c][7:0]   <= pwdata[7:0];
            2'h1:    lower_limit[c][15:8]  <= pwdata[7:0];
            default: lower_limit[c][19:16] <= pwdata[3:0];
          endcase
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      limits_touched <= 1'b0;
    end else if (wr_lim) begin
      limits_touched <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_enable       <= '0;
      averaging_enable <= 1'b0;
      averaging_ratio  <= range_check_pkg::RATIO_RESET;
    end else begin
      if (wr_ena) begin
        irq_enable <= pwdata[15:0];
      end
      if (wr_ctrl) begin
        averaging_enable <= pwdata[range_check_pkg::CTRL_EN_BIT];
        averaging_ratio  <= pwdata[range_check_pkg::CTRL_RAT_LSB +: 4];
      end
    end
  end

  // limit checks on every raw conversion, before any averaging
  logic [NUM_CHAN-1:0] over_hit;
  logic [NUM_CHAN-1:0] under_hit;

  for (genvar c = 0; c < NUM_CHAN; c++) begin : g_chk
    limit_compare #(
      .CODE_W (CODE_W)
    ) u_cmp (
      .code  (samples.code[c]),
      .upper (upper_limit[c]),
      .lower (lower_limit[c]),
      .check (samples.valid),  // RULE_03
      .over  (over_hit[c]),    // RULE_01
      .under (under_hit[c])    // RULE_01
    );
  end

  // sticky flags: a new hit wins over a clear in the same cycle
  wire logic [NUM_CHAN-1:0] clr_upper = wr_clr ? pwdata[range_check_pkg::UPPER_LSB +: NUM_CHAN] : '0;
  wire logic [NUM_CHAN-1:0] clr_lower = wr_clr ? pwdata[range_check_pkg::LOWER_LSB +: NUM_CHAN] : '0;
  wire logic [NUM_CHAN-1:0] next_upper = (upper_violation_flags & ~clr_upper) | over_hit;   // RULE_02
  wire logic [NUM_CHAN-1:0] next_lower = (lower_violation_flags & ~clr_lower) | under_hit;  // RULE_02

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      upper_violation_flags <= '0;
      lower_violation_flags <= '0;
    end else begin
      upper_violation_flags <= next_upper;  // RULE_09
      lower_violation_flags <= next_lower;  // RULE_09
    end
  end

  wire logic [15:0] status_word = 16'({lower_violation_flags, upper_violation_flags});
  assign irq = |(status_word & irq_enable);

  // read data captured in setup so it comes from a flop in the access phase
  wire logic [31:0] next_rdata = is_stat ? 32'(status_word) :
                                 is_ena  ? 32'(irq_enable) :
                                 is_ctrl ? 32'({averaging_ratio, 3'h0, averaging_enable}) :
                                 is_lim  ? 32'(limit_byte(dec.lower ? lower_limit[dec.chan] : upper_limit[dec.chan],
                                                          dec.sel)) :
                                 32'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= '0;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata  <= pwrite ? 32'h0 : next_rdata;
      pslverr <= !mapped;
    end
  end

  // averaging: one shared ratio, window of 2^(ratio+1) conversions
  logic signed [ACC_W-1:0] acc [NUM_CHAN];
  logic        [CNT_W-1:0] win_count;
  wire logic   [4:0]       shamt    = 5'({1'b0, averaging_ratio}) + 5'h01;
  wire logic   [CNT_W-1:0] win_last = CNT_W'((CNT_W+1)'(1) << shamt) - CNT_W'(1);
  wire logic               win_end  = samples.valid && (win_count == win_last);
  logic signed [ACC_W-1:0] sum [NUM_CHAN];

  always_comb begin
    for (int c = 0; c < NUM_CHAN; c++) begin
      sum[c] = acc[c] + ACC_W'($signed(samples.code[c]));
    end
  end

  // restart the window on any control write so the next sample opens it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      win_count <= '0;
      for (int c = 0; c < NUM_CHAN; c++) begin
        acc[c] <= '0;
      end
    end else if (wr_ctrl || !averaging_enable) begin
      win_count <= '0;
      for (int c = 0; c < NUM_CHAN; c++) begin
        acc[c] <= '0;
      end
    end else if (samples.valid) begin
      win_count <= win_end ? '0 : win_count + CNT_W'(1);
      for (int c = 0; c < NUM_CHAN; c++) begin
        acc[c] <= win_end ? '0 : sum[c];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      averaged <= '0;
    end else begin
      averaged.valid <= averaging_enable ? (win_end && !wr_ctrl) : samples.valid;  // RULE_08
      for (int c = 0; c < NUM_CHAN; c++) begin
        if (averaging_enable && win_end) begin
          averaged.code[c] <= CODE_W'(sum[c] >>> shamt);  // RULE_08
        end else if (!averaging_enable && samples.valid) begin
          averaged.code[c] <= samples.code[c];
        end
      end
    end
  end

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence read_setup_s;
    psel && !penable && !pwrite && is_stat;
  endsequence

  sequence unmapped_setup_s;
    psel && !penable && !mapped;
  endsequence

  sequence lim_read_s;
    psel && !penable && !pwrite && is_lim;
  endsequence

  sequence refused_write_s;
    psel && penable && pwrite && !mapped;
  endsequence

  sequence window_close_s;
    averaging_enable && win_end && !wr_ctrl;
  endsequence

  upper_set_a: assert property (samples.valid && ($signed(samples.code[7]) > $signed(upper_limit[7]))  // RULE_01
    |=> upper_violation_flags[7]) else $error("channel 7 over-range not flagged");
  under_set_a: assert property (samples.valid && ($signed(samples.code[0]) < $signed(lower_limit[0]))  // RULE_02
    |=> lower_violation_flags[0]) else $error("channel 0 under-range not flagged");
  no_false_flag_a: assert property (!samples.valid |=> (upper_violation_flags & ~$past(upper_violation_flags)) == '0)  // RULE_09
    else $error("over-range flag set without a sample");
  flag_hold_a: assert property (!wr_clr |=> ((upper_violation_flags & $past(upper_violation_flags)) ==  // RULE_09
    $past(upper_violation_flags))) else $error("over-range flag dropped without a clear");
  avg_raw_check_a: assert property (averaging_enable && samples.valid && over_hit[3] |=>  // RULE_03
    upper_violation_flags[3]) else $error("contributing sample not checked");
  default_limit_a: assert property (!limits_touched |-> upper_limit[5] == range_check_pkg::FS_POS &&  // RULE_04
    lower_limit[5] == range_check_pkg::FS_NEG) else $error("limit default lost");
  upper_write_a: assert property (wr_lim && !dec.lower && dec.sel == 2'h0 |=>  // RULE_06
    upper_limit[$past(dec.chan)][7:0] == $past(pwdata[7:0])) else $error("upper limit byte not written");
  lower_write_a: assert property (wr_lim && dec.lower && dec.sel == 2'h1 |=>  // RULE_07
    lower_limit[$past(dec.chan)][15:8] == $past(pwdata[7:0])) else $error("lower limit byte not written");
  raw_pass_a: assert property (!averaging_enable && samples.valid ##1 !averaging_enable |->  // RULE_08
    averaged.valid && averaged.code[2] == $past(samples.code[2])) else $error("raw result not presented");
  avg_only_a: assert property (averaging_enable && !win_end |=> !averaged.valid)  // RULE_08
    else $error("result presented inside window");
  status_read_a: assert property (read_setup_s |=> prdata[15:0] == $past(status_word))
    else $error("status read mismatch");
  unmapped_err_a: assert property (unmapped_setup_s |=> pslverr) else $error("unmapped access not refused");

  over_ch3_a: assert property (samples.valid && ($signed(samples.code[3]) > $signed(upper_limit[3]))  // RULE_02
    |=> upper_violation_flags[3]) else $error("channel 3 over-range not flagged");
  under_ch3_a: assert property (samples.valid && ($signed(samples.code[3]) < $signed(lower_limit[3]))  // RULE_02
    |=> lower_violation_flags[3]) else $error("channel 3 under-range not flagged");
  equal_upper_a: assert property (samples.valid && ($signed(samples.code[3]) <= $signed(upper_limit[3]))  // RULE_09
    |-> !over_hit[3]) else $error("in-range result counted as over");
  equal_lower_a: assert property (samples.valid && ($signed(samples.code[3]) >= $signed(lower_limit[3]))  // RULE_09
    |-> !under_hit[3]) else $error("in-range result counted as under");
  no_false_under_a: assert property (!samples.valid |=>  // RULE_09
    (lower_violation_flags & ~$past(lower_violation_flags)) == '0) else $error("under flag set with no sample");
  under_hold_a: assert property (!wr_clr |=> ((lower_violation_flags & $past(lower_violation_flags)) ==  // RULE_09
    $past(lower_violation_flags))) else $error("under-range flag dropped without a clear");
  clear_drop_a: assert property (wr_clr && !samples.valid |=>  // RULE_09
    (upper_violation_flags & $past(pwdata[range_check_pkg::UPPER_LSB +: NUM_CHAN])) == '0 &&
    (lower_violation_flags & $past(pwdata[range_check_pkg::LOWER_LSB +: NUM_CHAN])) == '0) else $error("flag not cleared");
  lim_read_ok_a: assert property (lim_read_s |=> !pslverr) else $error("limit read refused");  // RULE_06
  upper_read_a: assert property (lim_read_s ##0 (!dec.lower && dec.sel == 2'h0) |=>  // RULE_06
    prdata == 32'($past(upper_limit[dec.chan][7:0]))) else $error("upper limit byte misread");
  lower_read_a: assert property (lim_read_s ##0 (dec.lower && dec.sel == 2'h2) |=>  // RULE_07
    prdata == 32'($past(lower_limit[dec.chan][19:16]))) else $error("lower limit top misread");
  upper_top_write_a: assert property (wr_lim && !dec.lower && dec.sel == 2'h2 |=>  // RULE_06
    upper_limit[$past(dec.chan)][19:16] == $past(pwdata[3:0])) else $error("upper limit top not written");
  lower_low_write_a: assert property (wr_lim && dec.lower && dec.sel == 2'h0 |=>  // RULE_07
    lower_limit[$past(dec.chan)][7:0] == $past(pwdata[7:0])) else $error("lower limit byte not written");
  limit_kept_a: assert property (!wr_lim |=> $stable(upper_limit[3]) && $stable(lower_limit[3]))  // RULE_06
    else $error("limit changed without a write");
  refused_write_a: assert property (refused_write_s |=> $stable(irq_enable) && $stable(averaging_ratio))
    else $error("refused write took effect");
  write_reply_a: assert property (psel && !penable && pwrite |=> prdata == '0) else $error("write returned data");
  reply_held_a: assert property (!(psel && !penable) |=> $stable(prdata) && $stable(pslverr))
    else $error("read reply changed outside setup");
  window_bound_a: assert property (averaging_enable |-> win_count <= win_last)  // RULE_08
    else $error("window count overrun");
  avg_pulse_a: assert property (window_close_s |=> averaged.valid)  // RULE_08
    else $error("window end not presented");
  window_restart_a: assert property (wr_ctrl |=> win_count == '0)  // RULE_08
    else $error("control write did not restart the window");
  restart_quiet_a: assert property (wr_ctrl && averaging_enable |=> !averaged.valid)  // RULE_08
    else $error("result presented on a restart");
  idle_window_a: assert property (!averaging_enable |=> win_count == '0)  // RULE_08
    else $error("window counts while averaging is off");
  raw_hold_a: assert property (!averaging_enable && !samples.valid |=> $stable(averaged.code))  // RULE_08
    else $error("presented result changed without a sample");
  avg_hold_a: assert property (averaging_enable && !win_end |=> $stable(averaged.code))  // RULE_08
    else $error("presented average changed inside window");
  irq_quiet_a: assert property (upper_violation_flags == '0 && lower_violation_flags == '0 |-> !irq)
    else $error("interrupt without a flag");
  irq_raise_a: assert property (upper_violation_flags[3] && irq_enable[3] |-> irq)
    else $error("enabled flag did not interrupt");
endmodule : channel_range_limit_checker
`default_nettype wire

// *** test/sample_source.sv ***
`timescale 1ns/100ps
`default_nettype none
module sample_source (
  input  wire logic                          pclk,    // core clock
  input  wire logic                          presetn, // async reset, active low
  input  wire logic                          fire,    // launch one conversion set
  input  wire logic [7:0][19:0]              codes,   // codes for the next set
  output range_check_pkg::sample_bus_t       samples  // towards the checker
);
  // code lines toggle between conversions so a stale value is never mistaken for a sample
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      samples <= '0;
    end else begin
      samples.valid <= fire;
      samples.code  <= fire ? codes : ~samples.code;
    end
  end
endmodule : sample_source
`default_nettype wire

// *** test/channel_range_limit_checker_tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module channel_range_limit_checker_tb_top;
  logic                         pclk;
  logic                         presetn;
  logic                         psel;
  logic                         penable;
  logic                         pwrite;
  logic                         fire;
  logic [11:0]                  paddr;
  logic [31:0]                  pwdata;
  logic [31:0]                  prdata;
  logic [31:0]                  rd_data;
  logic                         pready;
  logic                         pslverr;
  logic                         rd_err;
  logic                         irq;
  logic [7:0][19:0]             codes;
  range_check_pkg::sample_bus_t samples;
  range_check_pkg::sample_bus_t averaged;
  int                           fail_count = 0;
  int                           n_checks = 0;

  channel_range_limit_checker dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .samples(samples), .averaged(averaged), .irq(irq)
  );
  sample_source src (.pclk(pclk), .presetn(presetn), .fire(fire), .codes(codes), .samples(samples));

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  task tally_and_finish;
    if (fail_count == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : tally_and_finish

  task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  // one full apb transfer; the wait on pready is bounded
  task apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {2'b00, idx, 2'b00};
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    if (n >= 64) begin
      fail_count++;
      tally_and_finish();
    end
    rd_data = prdata;
    rd_err  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task rd(input logic [7:0] idx, input logic [31:0] exp, input string msg);
    apb(1'b0, idx, 32'h0);
    chk(rd_data, exp, msg);
  endtask : rd

  task wlim(input logic [7:0] idx, input logic [19:0] v);
    apb(1'b1, idx, {24'h0, v[7:0]});
    apb(1'b1, idx + 8'h01, {24'h0, v[15:8]});
    apb(1'b1, idx + 8'h02, {28'h0, v[19:16]});
  endtask : wlim

  // the source registers fire, so the checker takes the set two edges later
  task send(input int ch, input logic [19:0] v);
    logic [7:0][19:0] c;
    c = '0;
    c[ch] = v;
    @(posedge pclk);
    codes <= c;
    fire  <= 1'b1;
    @(posedge pclk);
    fire <= 1'b0;
    @(posedge pclk);
    #1;
  endtask : send

  task t_reset_values;
    for (int c = 0; c < 8; c++) begin
      rd(range_check_pkg::CH_UPPER_IDX[c], 32'hff, "upper low byte");
      rd(range_check_pkg::CH_UPPER_IDX[c] + 8'h02, 32'h07, "upper top");
      rd(range_check_pkg::CH_LOWER_IDX[c] + 8'h01, 32'h00, "lower mid");
      rd(range_check_pkg::CH_LOWER_IDX[c] + 8'h02, 32'h08, "lower top");
    end
    rd(range_check_pkg::STATUS_IDX, 32'h0, "status idle");
    chk({31'h0, irq}, 32'h0, "irq idle");
  endtask : t_reset_values

  task t_flags;
    wlim(range_check_pkg::CH_UPPER_IDX[3], 20'h00100);
    wlim(range_check_pkg::CH_LOWER_IDX[3], 20'hfff00);
    rd(range_check_pkg::CH_LOWER_IDX[3] + 8'h02, 32'h0f, "lower readback");
    apb(1'b1, range_check_pkg::ENABLE_IDX, 32'h08);
    send(3, 20'h00100);
    rd(range_check_pkg::STATUS_IDX, 32'h0, "equal to upper");
    send(3, 20'h00101);
    chk({12'h0, averaged.code[3]}, 32'h00101, "raw passed");
    chk({31'h0, averaged.valid}, 32'h1, "raw valid");
    rd(range_check_pkg::STATUS_IDX, 32'h08, "over");
    chk({31'h0, irq}, 32'h1, "irq raised");
    send(3, 20'h00000);
    rd(range_check_pkg::STATUS_IDX, 32'h08, "sticky");
    apb(1'b1, range_check_pkg::ENABLE_IDX, 32'h00);
    #1;
    chk({31'h0, irq}, 32'h0, "irq masked");
    apb(1'b1, range_check_pkg::CLEAR_IDX, 32'h0000ffff);
    rd(range_check_pkg::STATUS_IDX, 32'h0, "cleared");
    send(3, 20'hfff00);
    send(5, 20'h80000);
    rd(range_check_pkg::STATUS_IDX, 32'h0, "equal to lower");
    send(3, 20'hffeff);
    rd(range_check_pkg::STATUS_IDX, 32'h0800, "under");
  endtask : t_flags

  // window of two: one sample above the limit hides inside an in-range average; then a window of four gives a negative average
  task t_average;
    apb(1'b1, range_check_pkg::CLEAR_IDX, 32'h0000ffff);
    apb(1'b1, range_check_pkg::CTRL_IDX, 32'h01);
    send(3, 20'h00200);
    chk({31'h0, averaged.valid}, 32'h0, "mid window");
    send(3, 20'h00000);
    chk({31'h0, averaged.valid}, 32'h1, "window end");
    chk({12'h0, averaged.code[3]}, 32'h100, "average");
    rd(range_check_pkg::STATUS_IDX, 32'h08, "contributor flagged");
    apb(1'b1, range_check_pkg::CTRL_IDX, 32'h11);
    rd(range_check_pkg::CTRL_IDX, 32'h11, "ctrl readback");
    send(3, 20'hffff8);
    send(3, 20'h00000);
    send(3, 20'h00000);
    chk({31'h0, averaged.valid}, 32'h0, "four open");
    send(3, 20'h00000);
    chk({31'h0, averaged.valid}, 32'h1, "four end");
    chk({12'h0, averaged.code[3]}, 32'h000ffffe, "negative average");
  endtask : t_average

  task t_unmapped;
    apb(1'b0, 8'h38, 32'h0);
    chk({31'h0, rd_err}, 32'h1, "gap error");
    chk(rd_data, 32'h0, "gap data");
    chk({31'h0, pready}, 32'h1, "no wait");
    apb(1'b1, 8'h38, 32'h000000ff);
    chk({31'h0, rd_err}, 32'h1, "gap write error");
    rd(range_check_pkg::CTRL_IDX, 32'h11, "gap write ignored");
  endtask : t_unmapped

  initial begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = '0;
    pwdata  = '0;
    fire    = 1'b0;
    codes   = '0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset_values();
    t_flags();
    t_average();
    t_unmapped();
    tally_and_finish();
  end
endmodule : channel_range_limit_checker_tb_top
`default_nettype wire
